// ### rtl/bit_timer.sv
// Purpose: Half-bit tick generator for the serial masters
// Assumes: half_cycles of at least 1
// Notes:   Dropping run restarts the count, so each phase after a pause is whole
`default_nettype none
module bit_timer #(
  parameter int CW = 16
) (
  input  wire logic          clk_sys,      // System clock
  input  wire logic          srst,         // Synchronous reset
  input  wire logic          run,          // Count while high
  input  wire logic [CW-1:0] half_cycles,  // Cycles per half bit
  output var  logic          tick          // One-cycle pulse per half bit
);
  logic [CW-1:0] cnt;

  always_ff @(posedge clk_sys) begin
    if (srst || !run) begin
      cnt  <= '0;
      tick <= 1'b0;
    end else if (cnt == half_cycles - 1'b1) begin
      cnt  <= '0;
      tick <= 1'b1;
    end else begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : bit_timer
`default_nettype wire

// ### rtl/byte_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH of at least 2
// Notes:   Full and empty come from an occupancy count, so no slot is wasted
`default_nettype none
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,  // System clock
  input wire logic srst,     // Synchronous reset
  fifo_if.store    q         // Fill and drain sides
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign q.in_ready  = (count != (AW+1)'(DEPTH));
  assign q.out_valid = (count != '0);
  assign q.out_data  = mem[rd_ptr];
  assign push        = q.in_valid & q.in_ready;
  assign pop         = q.out_valid & q.out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= q.in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst || q.flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo
`default_nettype wire

// ### rtl/fifo_if.sv
// Purpose: Valid/ready carrier between the byte feeder, the FIFO and the shift engine
// Assumes: Same clock on both sides
// Notes:   flush empties the store in one cycle
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8);
  logic             flush;
  logic [WIDTH-1:0] in_data;
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] out_data;
  logic             out_valid;
  logic             out_ready;

  modport store (input flush, in_data, in_valid, out_ready, output in_ready, out_data, out_valid);
  modport user  (output flush, in_data, in_valid, out_ready, input in_ready, out_data, out_valid);
endinterface : fifo_if
`default_nettype wire

// ### rtl/remote_serial_master_command.sv
// Purpose: Remote serial master command engine: runs SPI or 2-wire transfers set up through registers
// Assumes: Register port on clk_sys; SPI and 2-wire pins asynchronous to clk_sys
// Notes:   Pin inputs pass two flops, so the 8 Mbit/s SPI codes run at the fastest the clock allows
// Notes on behaviour
// - Receiver masters extend the transmitter control path; setup via command register 0x70.
// - Command bit 7 picks the master: 0 is 2-wire, 1 is SPI.
// - SPI bits 6:4 pick select line: 000/100 dedicated low, 001-011 low, 101-111 high.
// - The dedicated master chip select is always active low.
// - 2-wire bits 6:4: 000 start and stop, 001 start without closing stop.
// - Speed bits 3:1 set SPI rate 8M down to 250k; 111 means no access.
// - 2-wire speeds 001 100k, 010 400k, 011 1M; other codes illegal.
// - Command settings are taken only when 0x01 is written to execute.
// - Write and read byte counts come from 0x71 and 0x72; data uses buffer.
// - Writing execute after the counts starts a transfer on the chosen master.
// - Completion shows in the execute register and can raise an interrupt.
// - Counts and buffer are frozen at execute; later writes do not disturb it.
// - Write the programmed bytes first, then read bytes back into the buffer.
// - Execute reads 0 idle ok, 1 busy, 2 idle after failure.
// - Each byte count is at most 16 per command.
// - Transfer buffer occupies addresses 0x60 to 0x6F for outgoing and returned bytes.
`include "rsm_params.svh"
`default_nettype none
module remote_serial_master_command #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic               clk_sys,               // System clock, 10 MHz
  input  wire logic               srst,                  // Synchronous reset, active high
  input  wire logic               reg_wr,                // Register write strobe
  input  wire logic [7:0]         reg_addr,              // Register address
  input  wire rsm_pkg::byte_t     reg_wdata,             // Register write data
  output var  rsm_pkg::byte_t     reg_rdata,             // Read data, one cycle after address
  output var  logic               exec_done,             // Command finished pulse
  output var  logic               spi_sclk,              // SPI clock, mode 0
  output var  logic               spi_mosi,              // SPI data out
  input  wire logic               spi_miso,              // SPI data in
  output var  logic               master_chip_select_n,  // Dedicated select, active low
  output var  logic [2:0]         do_select_en,          // Output pin taken as select
  output var  logic [2:0]         do_select_level,       // Level for a taken pin
  input  wire logic               tw_scl_in,             // 2-wire clock pin level
  output var  logic               tw_scl_out,            // 2-wire clock drive value
  output var  logic               tw_scl_oe_n,           // 2-wire clock pull low, active low
  input  wire logic               tw_sda_in,             // 2-wire data pin level
  output var  logic               tw_sda_out,            // 2-wire data drive value
  output var  logic               tw_sda_oe_n            // 2-wire data pull low, active low
);
  import rsm_pkg::*;

  byte_t        cmd_reg;
  byte_t        wcnt_reg;
  byte_t        rcnt_reg;
  byte_t        xfer_buf [16];
  exec_status_e status;
  eng_state_e   state;
  logic [1:0]   step;
  byte_t        shreg;
  logic [3:0]   bitn;
  logic [4:0]   wleft;
  logic [4:0]   rleft;
  logic [4:0]   feed_left;
  logic [3:0]   feed_idx;
  logic [3:0]   ridx;
  logic         phase_rd;
  logic         failed;
  logic         act_spi;
  logic         act_stop;
  logic [2:0]   act_sel;
  logic [15:0]  act_half;
  logic         miso_m, miso_s, sda_m, sda_s, scl_m, scl_s;
  logic         tick, go, start_bus, tw_legal, busy, fin, in_s;
  logic         scl_low, sda_low, cs_on;
  logic [2:0]   speed;

  fifo_if #(.WIDTH(8)) feed ();

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .srst    (srst),
    .q       (feed.store)
  );

  bit_timer #(.CW(16)) u_timer (
    .clk_sys     (clk_sys),
    .srst        (srst),
    .run         (state == S_START || state == S_LOW || state == S_HIGH || state == S_STOP),
    .half_cycles (act_half),
    .tick        (tick)
  );

  function automatic logic [4:0] cap(input byte_t v);
    return (v > 8'(`MAX_BYTES)) ? `MAX_BYTES : v[4:0];
  endfunction : cap

  function automatic logic [15:0] half_of(input logic [31:0] rate);
    logic [31:0] h;
    h = `SYS_CLK_HZ / (32'd2 * rate);
    return (h == 32'd0) ? 16'd1 : h[15:0];
  endfunction : half_of

  function automatic logic [15:0] speed_half(input logic spi, input logic [2:0] code);
    logic [31:0] r;
    r = `RATE_250K;
    if (spi) begin
      case (code)
        3'h0, 3'h1: r = `RATE_8M;
        3'h2:       r = `RATE_4M;
        3'h3:       r = `RATE_2M;
        3'h4:       r = `RATE_1M;
        3'h5:       r = `RATE_500K;
        default:    r = `RATE_250K;
      endcase
    end else begin
      case (code)
        3'h1:    r = `RATE_100K;
        3'h2:    r = `RATE_400K;
        default: r = `RATE_1M;
      endcase
    end
    return half_of(r);
  endfunction : speed_half

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {miso_m, miso_s, sda_m, sda_s, scl_m, scl_s} <= 6'h3f;
    end else begin
      {miso_m, sda_m, scl_m} <= {spi_miso, tw_sda_in, tw_scl_in};
      {miso_s, sda_s, scl_s} <= {miso_m, sda_m, scl_m};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register port
  assign speed    = cmd_reg[`CMD_SPEED_HI:`CMD_SPEED_LO];
  assign tw_legal = (speed == 3'h1) || (speed == 3'h2) || (speed == 3'h3);
  assign go        = reg_wr && (reg_addr == `REG_EXEC) && (reg_wdata == `EXEC_GO) && (status != EXEC_BUSY);
  assign start_bus = go && (speed != `SPEED_NONE) && (cmd_reg[`CMD_IFSEL_BIT] || tw_legal);
  assign busy      = (state != S_IDLE);
  assign fin       = (state == S_STOP) && tick && (act_spi || step == 2'd2);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cmd_reg  <= `CMD_RESET;
      wcnt_reg <= `CNT_RESET;
      rcnt_reg <= `CNT_RESET;
    end else if (reg_wr && status != EXEC_BUSY) begin
      if (reg_addr == `REG_CMD) cmd_reg <= reg_wdata;
      if (reg_addr == `REG_WCNT) wcnt_reg <= reg_wdata;
      if (reg_addr == `REG_RCNT) rcnt_reg <= reg_wdata;
    end
  end

  // buffer; returned bytes have priority over the port
  always_ff @(posedge clk_sys) begin
    if (state == S_NEXT && phase_rd) begin
      xfer_buf[ridx] <= shreg;
    end else if (reg_wr && status != EXEC_BUSY && reg_addr[7:4] == `REG_BUF_BASE) begin
      xfer_buf[reg_addr[3:0]] <= reg_wdata;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      status    <= EXEC_OK;
      exec_done <= 1'b0;
    end else begin
      exec_done <= 1'b0;
      if (go) begin
        status    <= start_bus ? EXEC_BUSY : (speed == `SPEED_NONE) ? EXEC_OK : EXEC_FAIL;
        exec_done <= !start_bus;
      end else if (fin) begin
        status    <= failed ? EXEC_FAIL : EXEC_OK;
        exec_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_addr[7:4] == `REG_BUF_BASE) begin
      reg_rdata <= xfer_buf[reg_addr[3:0]];
    end else begin
      case (reg_addr)
        `REG_CMD:  reg_rdata <= cmd_reg;
        `REG_WCNT: reg_rdata <= wcnt_reg;
        `REG_RCNT: reg_rdata <= rcnt_reg;
        `REG_EXEC: reg_rdata <= {6'h00, status};
        default:   reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Feeder: streams the frozen write bytes into the FIFO ahead of the engine
  assign feed.flush     = start_bus;
  assign feed.in_valid  = (feed_left != 5'd0);
  assign feed.in_data   = xfer_buf[feed_idx];
  assign feed.out_ready = (state == S_LOAD) && !phase_rd;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      feed_left <= 5'd0;
      feed_idx  <= 4'h0;
    end else if (start_bus) begin
      feed_left <= cap(wcnt_reg);
      feed_idx  <= 4'h0;
    end else if (feed.in_valid && feed.in_ready) begin
      feed_left <= feed_left - 5'd1;
      feed_idx  <= feed_idx + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shift engine
  assign in_s = act_spi ? miso_s : sda_s;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state    <= S_IDLE;
      step     <= 2'd0;
      shreg    <= 8'hff;
      bitn     <= 4'h0;
      wleft    <= 5'd0;
      rleft    <= 5'd0;
      ridx     <= 4'h0;
      phase_rd <= 1'b0;
      failed   <= 1'b0;
      act_spi  <= 1'b0;
      act_stop <= 1'b1;
      act_sel  <= 3'h0;
      act_half <= 16'd1;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (start_bus) begin
            act_spi  <= cmd_reg[`CMD_IFSEL_BIT];
            act_sel  <= cmd_reg[`CMD_SEL_HI:`CMD_SEL_LO];
            act_stop <= (cmd_reg[`CMD_SEL_HI:`CMD_SEL_LO] == 3'h0);
            act_half <= speed_half(cmd_reg[`CMD_IFSEL_BIT], speed);
            wleft    <= cap(wcnt_reg);
            rleft    <= cap(rcnt_reg);
            phase_rd <= (cap(wcnt_reg) == 5'd0);
            ridx     <= 4'h0;
            failed   <= 1'b0;
            step     <= 2'd0;
            state    <= S_START;
          end
        end
        S_START: begin
          if (tick) begin
            state <= (wleft == 5'd0 && rleft == 5'd0) ? S_STOP : S_LOAD;
          end
        end
        S_LOAD: begin
          if (phase_rd || feed.out_valid) begin
            shreg <= phase_rd ? 8'hff : feed.out_data;
            bitn  <= 4'h0;
            state <= S_LOW;
          end
        end
        S_LOW: begin
          if (tick) begin
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          // Slave may stretch the 2-wire clock
          if (tick && (act_spi || scl_s)) begin
            if (bitn != 4'h8) begin
              shreg <= {shreg[6:0], in_s};
            end else if (!phase_rd) begin
              failed <= sda_s;
            end
            if ((act_spi && bitn == 4'h7) || bitn == 4'h8) begin
              state <= S_NEXT;
            end else begin
              bitn  <= bitn + 4'h1;
              state <= S_LOW;
            end
          end
        end
        S_NEXT: begin
          if (phase_rd) begin
            ridx  <= ridx + 4'h1;
            rleft <= rleft - 5'd1;
          end else begin
            wleft <= wleft - 5'd1;
          end
          if (failed) begin
            state <= S_STOP;
          end else if (!phase_rd && wleft != 5'd1) begin
            state <= S_LOAD;
          end else if (!phase_rd && rleft != 5'd0) begin
            phase_rd <= 1'b1;
            state    <= S_LOAD;
          end else if (phase_rd && rleft != 5'd1) begin
            state <= S_LOAD;
          end else begin
            state <= S_STOP;
          end
        end
        S_STOP: begin
          if (fin) begin
            state <= S_IDLE;
          end else if (tick) begin
            step <= step + 2'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered so the pins never glitch
  assign cs_on   = act_spi && busy;
  assign scl_low = !act_spi && busy && state != S_START && state != S_HIGH && !(state == S_STOP && step != 2'd0);
  // stop only when framing asks for it
  assign sda_low = !act_spi && busy && (state == S_START || state == S_LOAD
                   || (state == S_STOP && step != 2'd2 && act_stop)
                   || ((state == S_LOW || state == S_HIGH) &&
                       (phase_rd ? (bitn == 4'h8 && rleft != 5'd1) : (bitn != 4'h8 && !shreg[7]))));

  assign tw_scl_out = 1'b0;
  assign tw_sda_out = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      spi_sclk             <= 1'b0;
      spi_mosi             <= 1'b0;
      master_chip_select_n <= 1'b1;
      do_select_en         <= 3'h0;
      do_select_level      <= 3'h0;
      tw_scl_oe_n          <= 1'b1;
      tw_sda_oe_n          <= 1'b1;
    end else begin
      // mode 0, select held for the whole command
      spi_sclk             <= cs_on && state == S_HIGH;
      spi_mosi             <= cs_on && (phase_rd || shreg[7]);
      // dedicated select is low-active for both of its codes
      master_chip_select_n <= !(cs_on && act_sel[1:0] == 2'b00);
      for (int i = 0; i < 3; i++) begin
        do_select_en[i]    <= cs_on && act_sel[1:0] == 2'(i + 1);
        do_select_level[i] <= act_sel[2];
      end
      tw_scl_oe_n          <= !scl_low;
      tw_sda_oe_n          <= !sda_low;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_go_starts_bus: assert property (start_bus |=> state == S_START && status == EXEC_BUSY)
    else $error("Execute did not start the bus");
  a_illegal_fails: assert property ((go && !cmd_reg[7] && !tw_legal && speed != `SPEED_NONE)
    |=> state == S_IDLE && status == EXEC_FAIL && exec_done) else $error("Illegal speed not refused");
  a_no_access: assert property ((go && speed == `SPEED_NONE) |=> state == S_IDLE && status == EXEC_OK)
    else $error("No-access code touched the bus");
  a_busy_status: assert property (busy |-> status == EXEC_BUSY)
    else $error("Status not busy during transfer");
  a_dedicated_low: assert property ((cs_on && act_sel[1:0] == 2'b00) [*2] |-> !master_chip_select_n)
    else $error("Dedicated select not low");
  a_write_first: assert property ((busy && phase_rd) |-> wleft == 5'd0)
    else $error("Read started before writes ended");
  a_count_cap: assert property (wleft <= `MAX_BYTES && rleft <= `MAX_BYTES)
    else $error("Byte count above limit");
  a_cmd_frozen: assert property ((busy && $past(busy)) |-> $stable(act_half) && $stable(act_sel))
    else $error("Command changed during transfer");
  a_regs_locked: assert property ((reg_wr && status == EXEC_BUSY) |=> $stable(wcnt_reg) && $stable(cmd_reg))
    else $error("Register changed while busy");
  a_done_idle: assert property (exec_done |-> status != EXEC_BUSY && $past(status) != EXEC_OK || $past(go))
    else $error("Done without completion");
  a_sda_steady: assert property ((!act_spi && $past(state) == S_HIGH && $past(state, 2) == S_HIGH)
    |-> $stable(tw_sda_oe_n)) else $error("Data moved while 2-wire clock high");

  c_spi_done:  cover property (fin && act_spi && rleft == 5'd0);
  c_tw_ok:     cover property (fin && !act_spi && !failed && phase_rd);
  c_tw_nack:   cover property (fin && failed);
  c_fifo_full: cover property (!feed.in_ready);
endmodule : remote_serial_master_command
`default_nettype wire

// ### rtl/rsm_params.svh
// Purpose: Register offsets, field positions, reset values and timing for the remote serial master
// Assumes: Byte-wide register port, 10 MHz system clock
// Notes:   Definitions only
`ifndef RSM_PARAMS_SVH
`define RSM_PARAMS_SVH

`define REG_BUF_BASE   4'h6
`define REG_CMD        8'h70
`define REG_WCNT       8'h71
`define REG_RCNT       8'h72
`define REG_EXEC       8'h74

`define CMD_RESET      8'h00
`define CNT_RESET      8'h00
`define EXEC_GO        8'h01

`define CMD_IFSEL_BIT  7
`define CMD_SEL_HI     6
`define CMD_SEL_LO     4
`define CMD_SPEED_HI   3
`define CMD_SPEED_LO   1
`define SPEED_NONE     3'h7

`define MAX_BYTES      5'd16

`define SYS_CLK_HZ     32'd10000000
`define RATE_8M        32'd8000000
`define RATE_4M        32'd4000000
`define RATE_2M        32'd2000000
`define RATE_1M        32'd1000000
`define RATE_500K      32'd500000
`define RATE_250K      32'd250000
`define RATE_400K      32'd400000
`define RATE_100K      32'd100000

`endif

// ### rtl/rsm_pkg.sv
// Purpose: Types shared by the remote serial master files
// Assumes: Nothing beyond SystemVerilog
// Notes:   Constants live in rsm_params.svh
`default_nettype none
package rsm_pkg;
  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    EXEC_OK   = 2'b00,
    EXEC_BUSY = 2'b01,
    EXEC_FAIL = 2'b10
  } exec_status_e;

  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_LOAD  = 3'b010,
    S_LOW   = 3'b011,
    S_HIGH  = 3'b100,
    S_NEXT  = 3'b101,
    S_STOP  = 3'b110
  } eng_state_e;
endpackage : rsm_pkg
`default_nettype wire

// ### tb/spi_peer.sv
// Purpose: Behavioural SPI slave beside the remote serial master
// Assumes: Mode 0, MSB first, select active low at sel_n
// Notes:   Returns REPLY on every byte and keeps the first byte it hears
`default_nettype none
module spi_peer #(
  parameter logic [7:0] REPLY = 8'ha5
) (
  input  wire logic       sclk,      // Serial clock from the master
  input  wire logic       mosi,      // Data from the master
  input  wire logic       sel_n,     // Resolved select, low when chosen
  output var  logic       miso,      // Data to the master
  output var  logic [7:0] first_rx   // First byte heard in a frame
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  int         n  = 0;
  initial miso = 1'b1;
  always @(negedge sel_n) begin
    n = 0;
    sh = REPLY;
    miso = REPLY[7];
  end
  // Released line shows the inverse, not the last bit
  always @(posedge sel_n) miso = ~miso;
  always @(posedge sclk) if (!sel_n) begin
    rx = {rx[6:0], mosi};
    n++;
    if (n == 8) first_rx = rx;
  end
  always @(negedge sclk) if (!sel_n) begin
    sh = (n % 8 == 0) ? REPLY : {sh[6:0], 1'b0};
    miso = sh[7];
  end
endmodule : spi_peer
`default_nettype wire

// ### tb/tb_remote_serial_master_command.sv
// Purpose: Self-checking bench for the remote serial master command engine
// Assumes: Inputs change on the falling clock edge
// Notes:   2-wire lines modelled with pull-ups; only zero-count frames run there
`default_nettype none
module tb_remote_serial_master_command;
  timeunit 1ns;
  timeprecision 1ps;
  import rsm_pkg::*;
  logic clk_sys = 0, srst = 1, reg_wr = 0, spi_miso, cs_seen, tw_act;
  logic [7:0] reg_addr = 8'h00, rx0;
  byte_t reg_wdata = 8'h00, reg_rdata, rd;
  logic exec_done, spi_sclk, spi_mosi, mcs_n, scl_out, scl_oe_n, sda_out, sda_oe_n, sel_n;
  logic [2:0] do_en, do_lvl, en_seen, lvl_seen;
  int bad_count = 0, check_count = 0, cyc = 0, dones = 0;
  initial forever #50 clk_sys = ~clk_sys;
  assign sel_n = mcs_n & ~(do_en[0] & do_lvl[0]) & ~(do_en[0] & ~do_lvl[0]);
  remote_serial_master_command dut (.clk_sys(clk_sys), .srst(srst), .reg_wr(reg_wr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .exec_done(exec_done), .spi_sclk(spi_sclk),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso), .master_chip_select_n(mcs_n), .do_select_en(do_en),
    .do_select_level(do_lvl), .tw_scl_in(scl_oe_n), .tw_scl_out(scl_out), .tw_scl_oe_n(scl_oe_n),
    .tw_sda_in(sda_oe_n), .tw_sda_out(sda_out), .tw_sda_oe_n(sda_oe_n));
  spi_peer peer (.sclk(spi_sclk), .mosi(spi_mosi), .sel_n(sel_n), .miso(spi_miso), .first_rx(rx0));
  always @(posedge clk_sys) begin
    cyc++;
    if (!mcs_n) cs_seen = 1;
    if (!scl_oe_n || !sda_oe_n) tw_act = 1;
    en_seen |= do_en;
    lvl_seen |= do_lvl & do_en;
    if (exec_done === 1'b1) dones++;
    if (cyc == 60000) begin
      bad_count++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1; reg_addr = a; reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask : wr
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rdr
  // every command goes through the receiver's own masters
  // Starts a command, then polls status under a bound
  task automatic run(input logic [7:0] cmd, input logic [7:0] exp_st);
    cs_seen = 0; tw_act = 0; en_seen = 0; lvl_seen = 0; dones = 0;
    wr(8'h70, cmd);
    wr(8'h74, 8'h01);
    for (int i = 0; i < 300; i++) begin
      rdr(8'h74, rd);
      if (rd !== 8'h01) break;
    end
    check("status", rd, exp_st);  // final status
    check("done pulses", 8'(dones), 8'h01);  // completion pulse
  endtask : run
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rdr(8'h70, rd); check("cmd reset", rd, 8'h00);  // command register
    rdr(8'h71, rd); check("wcnt reset", rd, 8'h00);  // write count register
    rdr(8'h73, rd); check("gap reads zero", rd, 8'h00);  // unmapped address
    rdr(8'h74, rd); check("exec reset", rd, 8'h00);  // idle ok
  endtask : t_reset
  task automatic t_spi();
    wr(8'h60, 8'h3c); wr(8'h71, 8'h01); wr(8'h72, 8'h01);
    wr(8'h70, 8'h88);
    cs_seen = 0; dones = 0;
    wr(8'h74, 8'h01);
    rdr(8'h74, rd); check("busy", rd, 8'h01);  // busy reading
    wr(8'h71, 8'h05);
    run(8'h88, 8'h00);
    check("dedicated select", 8'(cs_seen), 8'h01);  // select active low
    check("byte written", rx0, 8'h3c);  // write first
    rdr(8'h60, rd); check("byte read", rd, 8'ha5);  // read back to buffer
    rdr(8'h71, rd); check("count frozen", rd, 8'h01);  // writes refused while busy
  endtask : t_spi
  task automatic t_pin_select();
    wr(8'h60, 8'h00); wr(8'h71, 8'h00);
    run(8'hd8, 8'h00);
    check("pin taken", 8'(en_seen), 8'h01);  // pin 0 select
    check("pin level high", 8'(lvl_seen), 8'h01);  // active high code
    check("no dedicated", 8'(cs_seen), 8'h00);  // SPI pin routing
    rdr(8'h60, rd); check("pin read", rd, 8'ha5);  // buffer receives data
    run(8'hc8, 8'h00);
    check("code 100 dedicated", 8'(cs_seen), 8'h01);  // low whatever the polarity bit
    check("code 100 no pin", 8'(en_seen), 8'h00);  // dedicated select code
  endtask : t_pin_select
  task automatic t_no_access();
    wr(8'h72, 8'h00);  // nothing to exchange
    run(8'h8e, 8'h00);
    check("no bus", 8'(cs_seen), 8'h00);  // no-access code
  endtask : t_no_access
  task automatic t_two_wire();
    wr(8'h72, 8'h00);
    for (int c = 0; c < 4; c++) begin
      run({4'h0, 3'(c == 0 ? 0 : c + 3), 1'b0}, 8'h02);  // illegal speed fails
      check("idle lines", 8'(tw_act), 8'h00);  // illegal speeds
    end
    run(8'h16, 8'h00);
    check("start only", 8'(tw_act), 8'h01);  // start without stop
    run(8'h06, 8'h00);
    check("frame", 8'(tw_act), 8'h01);  // repeated start, then stop
    run(8'h02, 8'h00);
    check("slow frame", 8'(tw_act), 8'h01);  // 100 kbit/s
    run(8'h04, 8'h00);
    check("mid frame", 8'(tw_act), 8'h01);  // 400 kbit/s
  endtask : t_two_wire
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (8) @(negedge clk_sys);
    srst = 0;
    t_reset();
    t_spi();
    t_pin_select();
    t_no_access();
    t_two_wire();
    print_verdict();
  end
endmodule : tb_remote_serial_master_command
`default_nettype wire
